//--- common/ifsb_map.svh
`ifndef IFSB_MAP_SVH
`define IFSB_MAP_SVH

// Byte offsets of the registers on the bus, one aligned word each.
`define IFSB_OFF_THIRD 8'h00
`define IFSB_OFF_FOURTH 8'h04
`define IFSB_OFF_MASK_THIRD 8'h08
`define IFSB_OFF_MASK_FOURTH 8'h0c
`define IFSB_OFF_CLR_THIRD 8'h10
`define IFSB_OFF_CLR_FOURTH 8'h14
`define IFSB_OFF_PENDING 8'h18

// Flag positions inside the third flag register.
`define IFSB_BIT_CALENDAR 14
`define IFSB_BIT_I2C2_MASTER 2
`define IFSB_BIT_I2C2_SLAVE 1

// Flag positions inside the fourth flag register.
`define IFSB_BIT_LOW_VOLTAGE 8
`define IFSB_BIT_CHECKSUM 3
`define IFSB_BIT_UART2_ERR 2
`define IFSB_BIT_UART1_ERR 1

// Implemented bit masks and reset values.
`define IFSB_IMPL_THIRD 16'h4006
`define IFSB_IMPL_FOURTH 16'h010e
`define IFSB_RESET_FLAGS 16'h0000

// Bit of the pending register that reports the fourth register's half.
`define IFSB_PEND_FOURTH_LSB 16

`endif

//--- common/ifsb_pkg.sv
package ifsb_pkg;

	// One 16-bit flag register image.
	typedef logic [15:0] ifsb_flags_t;

	// Bus slave phase.
	typedef enum logic [0:0] {
		IFSB_ST_IDLE,
		IFSB_ST_ANSWER
	} ifsb_state_t;

endpackage

//--- verilog/ifsb_flag_reg.sv
// One flag register: hardware sets, software writes or clears by ones.
module ifsb_flag_reg #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] IMPL = '0
) (
	// Clock, reset and enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	// Hardware set pulses, one per bit.
	input wire logic [WIDTH-1:0] set_pulse,
	// Software write with lane mask.
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_mask,
	input wire logic [WIDTH-1:0] wr_data,
	// Software write-one-to-clear.
	input wire logic clr_en,
	input wire logic [WIDTH-1:0] clr_data,
	// Stored flags.
	output logic [WIDTH-1:0] flags_q
);
	import ifsb_pkg::*;

	genvar i;

	// Each implemented bit is a flop; the others are tied to zero.
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			if (IMPL[i])
			begin : g_impl
				logic bit_q;
				logic bit_d;
				logic wr_bit;
				logic clr_bit;

				// A set pulse in the same cycle as a write or clear wins.
				assign wr_bit = wr_en && wr_mask[i];
				assign clr_bit = clr_en && clr_data[i];
				assign bit_d = set_pulse[i] | (clr_bit ? 1'b0 : (wr_bit ? wr_data[i] : bit_q));

				// Each bit has its own flop, so the output has one driver per bit.
				assign flags_q[i] = bit_q;

				// Flag storage, held while the enable is low.
				always_ff @(posedge pclk or negedge presetn)
				begin
					if (!presetn)
						bit_q <= 1'b0;
					else if (pce)
						bit_q <= bit_d;
				end

				a_flag_set_sticks: assert property (@(posedge pclk) disable iff (!presetn)
					pce && set_pulse[i] |=> flags_q[i])
					else $error("Flag did not set after its source pulsed.");
				a_flag_write_zero: assert property (@(posedge pclk) disable iff (!presetn)
					pce && wr_bit && !wr_data[i] && !set_pulse[i] && !clr_bit |=> !flags_q[i])
					else $error("Flag did not take a written zero.");
			end
			else
			begin : g_none
				assign flags_q[i] = 1'b0;
			end
		end
	endgenerate

endmodule // ifsb_flag_reg

//--- verilog/ifsb_top.sv
// fourth bit 1, and all flags clear to zero at reset.
//
`include "ifsb_map.svh"

module ifsb_top #(
	parameter int ADDR_W = 12
) (
	// Clock, reset and enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt source pulses, same clock domain.
	input wire logic calendar_clock_event,
	input wire logic i2c_port2_master_event,
	input wire logic i2c_port2_slave_event,
	input wire logic low_voltage_detect_event,
	input wire logic checksum_generator_event,
	input wire logic uart_port2_error_event,
	input wire logic uart_port1_error_event,
	// Interrupt request.
	output logic irq
);
	import ifsb_pkg::*;

	// The offsets need eight address bits.
	generate
		if (ADDR_W < 8)
		begin : g_bad_addr
			$error("ADDR_W must be at least 8.");
		end
	endgenerate

	// Offset decode, used for every register.
	function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
		addr_hit = (addr == ADDR_W'(off));
	endfunction

	// Bus slave state.
	ifsb_state_t state_q;
	ifsb_state_t state_d;
	// Flag, mask and pending images.
	ifsb_flags_t flag_status_third;
	ifsb_flags_t flag_status_fourth;
	ifsb_flags_t mask_third_q;
	ifsb_flags_t mask_fourth_q;
	ifsb_flags_t mask_third_d;
	ifsb_flags_t mask_fourth_d;
	ifsb_flags_t set_third;
	ifsb_flags_t set_fourth;
	ifsb_flags_t lane_mask;
	ifsb_flags_t pend_third;
	ifsb_flags_t pend_fourth;
	// Bus data, answer and decode results.
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [31:0] read_word;
	logic pready_q;
	logic pslverr_q;
	logic pslverr_d;
	logic irq_q;
	logic irq_d;
	logic access;
	logic commit;
	logic wr_commit;
	logic hit_third;
	logic hit_fourth;
	logic hit_mask_third;
	logic hit_mask_fourth;
	logic hit_clr_third;
	logic hit_clr_fourth;
	logic hit_pending;
	logic hit_any;

	// Address decode for every register.
	assign hit_third = addr_hit(paddr, `IFSB_OFF_THIRD);
	assign hit_fourth = addr_hit(paddr, `IFSB_OFF_FOURTH);
	assign hit_mask_third = addr_hit(paddr, `IFSB_OFF_MASK_THIRD);
	assign hit_mask_fourth = addr_hit(paddr, `IFSB_OFF_MASK_FOURTH);
	assign hit_clr_third = addr_hit(paddr, `IFSB_OFF_CLR_THIRD);
	assign hit_clr_fourth = addr_hit(paddr, `IFSB_OFF_CLR_FOURTH);
	assign hit_pending = addr_hit(paddr, `IFSB_OFF_PENDING);
	assign hit_any = hit_third | hit_fourth | hit_mask_third | hit_mask_fourth
		| hit_clr_third | hit_clr_fourth | hit_pending;

	// Bus phase: the answer comes one cycle into the access phase.
	// Read data is captured at the first access edge, while a write waits for the ready edge,
	// so a refused write never reaches a flag or a mask.
	assign access = psel && penable && (state_q == IFSB_ST_IDLE);
	assign commit = psel && penable && pready_q;
	assign wr_commit = commit && pwrite && !pslverr_q;
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// Hardware set pulses placed at their flag positions.
	always_comb
	begin
		set_third = '0;
		set_fourth = '0;
		set_third[`IFSB_BIT_CALENDAR] = calendar_clock_event;
		set_third[`IFSB_BIT_I2C2_MASTER] = i2c_port2_master_event;
		set_third[`IFSB_BIT_I2C2_SLAVE] = i2c_port2_slave_event;
		set_fourth[`IFSB_BIT_LOW_VOLTAGE] = low_voltage_detect_event;
		set_fourth[`IFSB_BIT_CHECKSUM] = checksum_generator_event;
		set_fourth[`IFSB_BIT_UART2_ERR] = uart_port2_error_event;
		set_fourth[`IFSB_BIT_UART1_ERR] = uart_port1_error_event;
	end

	// Third flag register.
	ifsb_flag_reg #(
		.WIDTH(16),
		.IMPL(`IFSB_IMPL_THIRD)
	) u_third (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.set_pulse(set_third),
		.wr_en(wr_commit && hit_third),
		.wr_mask(lane_mask),
		.wr_data(pwdata[15:0]),
		.clr_en(wr_commit && hit_clr_third),
		.clr_data(pwdata[15:0] & lane_mask),
		.flags_q(flag_status_third)
	);

	// Fourth flag register.
	ifsb_flag_reg #(
		.WIDTH(16),
		.IMPL(`IFSB_IMPL_FOURTH)
	) u_fourth (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.set_pulse(set_fourth),
		.wr_en(wr_commit && hit_fourth),
		.wr_mask(lane_mask),
		.wr_data(pwdata[15:0]),
		.clr_en(wr_commit && hit_clr_fourth),
		.clr_data(pwdata[15:0] & lane_mask),
		.flags_q(flag_status_fourth)
	);

	// Mask registers keep only implemented positions.
	assign mask_third_d = (wr_commit && hit_mask_third)
		? (((mask_third_q & ~lane_mask) | (pwdata[15:0] & lane_mask)) & `IFSB_IMPL_THIRD)
		: mask_third_q;
	assign mask_fourth_d = (wr_commit && hit_mask_fourth)
		? (((mask_fourth_q & ~lane_mask) | (pwdata[15:0] & lane_mask)) & `IFSB_IMPL_FOURTH)
		: mask_fourth_q;

	// Pending view and interrupt level.
	assign pend_third = flag_status_third & mask_third_q;
	assign pend_fourth = flag_status_fourth & mask_fourth_q;
	assign irq_d = |{pend_third, pend_fourth};

	// Read mux; unmapped reads return zero.
	assign read_word = hit_third ? {16'h0000, flag_status_third}
		: hit_fourth ? {16'h0000, flag_status_fourth}
		: hit_clr_third ? {16'h0000, flag_status_third}
		: hit_clr_fourth ? {16'h0000, flag_status_fourth}
		: hit_mask_third ? {16'h0000, mask_third_q}
		: hit_mask_fourth ? {16'h0000, mask_fourth_q}
		: hit_pending ? {pend_fourth, pend_third}
		: 32'h0000_0000;

	// Answer data and error captured as the access phase starts.
	assign prdata_d = (access && !pwrite) ? read_word : prdata_q;
	assign pslverr_d = access ? !hit_any : (commit ? 1'b0 : pslverr_q);

	// Slave phase: idle, then one answering cycle.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			IFSB_ST_IDLE:
				if (access)
					state_d = IFSB_ST_ANSWER;
			IFSB_ST_ANSWER:
				state_d = IFSB_ST_IDLE;
			default:
				state_d = IFSB_ST_IDLE;
		endcase
	end

	// Bus slave flops.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= IFSB_ST_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else if (pce)
		begin
			state_q <= state_d;
			pready_q <= access;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// Mask and interrupt flops.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_third_q <= `IFSB_RESET_FLAGS;
			mask_fourth_q <= `IFSB_RESET_FLAGS;
			irq_q <= 1'b0;
		end
		else if (pce)
		begin
			mask_third_q <= mask_third_d;
			mask_fourth_q <= mask_fourth_d;
			irq_q <= irq_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;

	// Unimplemented positions never read as one.
	a_unimpl_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
		((flag_status_third & ~`IFSB_IMPL_THIRD) == 16'h0000)
		&& ((flag_status_fourth & ~`IFSB_IMPL_FOURTH) == 16'h0000))
		else $error("An unimplemented flag bit reads as one.");

	a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && !hit_pending |-> prdata[31:16] == 16'h0000)
		else $error("Upper half of a flag read is not zero.");

	// Each source lands on its own bit.
	a_i2c_master_bit: assert property (@(posedge pclk) disable iff (!presetn)
		pce && i2c_port2_master_event |=> flag_status_third[2])
		else $error("Second I2C master event did not set third bit 2.");

	a_i2c_slave_bit: assert property (@(posedge pclk) disable iff (!presetn)
		pce && i2c_port2_slave_event |=> flag_status_third[1])
		else $error("Second I2C slave event did not set third bit 1.");

	a_checksum_bit: assert property (@(posedge pclk) disable iff (!presetn)
		pce && checksum_generator_event |=> flag_status_fourth[3])
		else $error("Checksum event did not set fourth bit 3.");

	a_uart2_err_bit: assert property (@(posedge pclk) disable iff (!presetn)
		pce && uart_port2_error_event |=> flag_status_fourth[2])
		else $error("Second UART error did not set fourth bit 2.");

	a_calendar_bit: assert property (@(posedge pclk) disable iff (!presetn)
		pce && calendar_clock_event |=> flag_status_third[14])
		else $error("Calendar event did not set third bit 14.");

	a_low_voltage_bit: assert property (@(posedge pclk) disable iff (!presetn)
		pce && low_voltage_detect_event |=> flag_status_fourth[8])
		else $error("Low voltage event did not set fourth bit 8.");

	a_uart1_err_bit: assert property (@(posedge pclk) disable iff (!presetn)
		pce && uart_port1_error_event |=> flag_status_fourth[1])
		else $error("First UART error did not set fourth bit 1.");

	a_flag_reset_zero: assert property (@(posedge pclk)
		$rose(presetn) |-> flag_status_third == 16'h0000 && flag_status_fourth == 16'h0000)
		else $error("Flags are not zero just after reset.");

	a_set_beats_write: assert property (@(posedge pclk) disable iff (!presetn)
		pce && wr_commit && hit_third && !pwdata[2] && i2c_port2_master_event
		|=> flag_status_third[2])
		else $error("A software write lost a same-cycle set.");

	a_bus_two_cycles: assert property (@(posedge pclk) disable iff (!presetn)
		pce && psel && !penable ##1 pce && psel && penable && !pready |=> pready)
		else $error("Access did not answer on its second cycle.");

	// Ready is a single-cycle answer.
	a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		pce && pready |=> !pready)
		else $error("Ready stood for more than one cycle.");

	// An unmapped address is answered with an error, a mapped one without.
	a_error_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		pce && access |=> pready && (pslverr == $past(!hit_any)))
		else $error("Error answer does not match the address decode.");

	// The interrupt level follows the masked flags one cycle later.
	a_irq_follows_pend: assert property (@(posedge pclk) disable iff (!presetn)
		pce |=> irq == $past((|(flag_status_third & mask_third_q))
		|| (|(flag_status_fourth & mask_fourth_q))))
		else $error("Interrupt level does not follow the masked flags.");

	// With both masks clear the interrupt stays low.
	a_irq_masked_low: assert property (@(posedge pclk) disable iff (!presetn)
		pce && (mask_third_q == 16'h0000) && (mask_fourth_q == 16'h0000) |=> !irq)
		else $error("Interrupt raised with every source masked.");

	// A one written to the clear alias drops the flag when no set competes.
	a_clear_alias_works: assert property (@(posedge pclk) disable iff (!presetn)
		pce && wr_commit && hit_clr_third && pwdata[2] && pstrb[0]
		&& !i2c_port2_master_event
		|=> !flag_status_third[2])
		else $error("A one written to the clear alias left the flag set.");

	// Masks never hold a bit at an unimplemented position.
	a_mask_impl_only: assert property (@(posedge pclk) disable iff (!presetn)
		((mask_third_q & ~`IFSB_IMPL_THIRD) == 16'h0000)
		&& ((mask_fourth_q & ~`IFSB_IMPL_FOURTH) == 16'h0000))
		else $error("A mask bit is set at an unimplemented position.");

	// A read of the third register returns the flags seen as the access began.
	a_read_data_third: assert property (@(posedge pclk) disable iff (!presetn)
		pce && access && !pwrite && hit_third |=> prdata == {16'h0000, $past(flag_status_third)})
		else $error("Read data differs from the third flag register.");

	// A full write with no competing set lands on the implemented bits only.
	a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
		pce && wr_commit && hit_fourth && (pstrb[1:0] == 2'b11) && (set_fourth == 16'h0000)
		|=> flag_status_fourth == ($past(pwdata[15:0]) & `IFSB_IMPL_FOURTH))
		else $error("A write to the fourth register did not land.");

	// With the enable low the flags stand still.
	a_flags_freeze: assert property (@(posedge pclk) disable iff (!presetn)
		!pce |=> $stable(flag_status_third) && $stable(flag_status_fourth))
		else $error("A flag changed while the enable was low.");

endmodule // ifsb_top

//--- tb/tb.sv
`include "ifsb_map.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// Bench drives, all given a value at time zero.
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic pce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [6:0] ev = 7'h00;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [31:0] rd;
	logic [31:0] er;
	int miscompares = 0;
	int cmp_count = 0;

	// The design under test; the clock enable is driven so that a freeze can be tried.
	ifsb_top uut (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.calendar_clock_event(ev[0]),
		.i2c_port2_master_event(ev[1]),
		.i2c_port2_slave_event(ev[2]),
		.low_voltage_detect_event(ev[3]),
		.checksum_generator_event(ev[4]),
		.uart_port2_error_event(ev[5]),
		.uart_port1_error_event(ev[6]),
		.irq(irq)
	);

	// Free-running clock at 50 MHz.
	always #10 pclk = ~pclk;

	// Counts every comparison and reports a mismatch at once.
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// One APB transfer; the request stands until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// Flops update later in the time step, so these reads see what the edge samples.
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
	endtask

	task automatic rdw(input logic [11:0] a);
		apb(1'b0, a, 32'h0, 4'hf);
	endtask

	// One cycle high on a source input.
	task automatic pulse(input int i);
		@(posedge pclk);
		ev[i] <= 1'b1;
		@(posedge pclk);
		ev[i] <= 1'b0;
	endtask

	// Both flag registers and the interrupt start cleared.
	task automatic t_reset;
		rdw(`IFSB_OFF_THIRD);
		chk("third after reset", 32'h0, rd);
		rdw(`IFSB_OFF_FOURTH);
		chk("fourth after reset", 32'h0, rd);
		chk("irq after reset", 32'h0, {31'h0, irq});
		$display("test reset done");
	endtask

	// A source sets exactly its own bit, raises irq when unmasked, clears by one.
	task automatic t_src(input int i, input bit fourth, input int b);
		logic [11:0] fa;
		logic [31:0] m;
		fa = fourth ? 12'(`IFSB_OFF_FOURTH) : 12'(`IFSB_OFF_THIRD);
		m = 32'h1 << b;
		wr(fa + 12'h008, m);
		pulse(i);
		rdw(fa);
		chk("flag set", m, rd);
		rdw(12'(`IFSB_OFF_PENDING));
		chk("pending", fourth ? m << 16 : m, rd);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(fa + 12'h010, m);
		rdw(fa);
		chk("flag cleared", 32'h0, rd);
		chk("irq dropped", 32'h0, {31'h0, irq});
		wr(fa + 12'h008, 32'h0);
		$display("test source %0d done", i);
	endtask

	// Unassigned positions read zero; writes land on implemented bits only.
	task automatic t_unimpl;
		wr(`IFSB_OFF_THIRD, 32'hffff_ffff);
		rdw(`IFSB_OFF_THIRD);
		chk("third all ones", 32'h4006, rd);
		wr(`IFSB_OFF_FOURTH, 32'hffff_ffff);
		rdw(`IFSB_OFF_FOURTH);
		chk("fourth all ones", 32'h010e, rd);
		wr(`IFSB_OFF_THIRD, 32'h0);
		apb(1'b1, `IFSB_OFF_THIRD, 32'hffff, 4'h1);
		rdw(`IFSB_OFF_THIRD);
		chk("third low lane", 32'h0006, rd);
		wr(`IFSB_OFF_THIRD, 32'h0);
		wr(`IFSB_OFF_FOURTH, 32'h0);
		rdw(`IFSB_OFF_FOURTH);
		chk("fourth written zero", 32'h0, rd);
		$display("test unimplemented done");
	endtask

	// A masked source sets its flag but not the interrupt.
	task automatic t_masked;
		pulse(4);
		repeat (3) @(posedge pclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		rdw(`IFSB_OFF_FOURTH);
		chk("checksum flag", 32'h0008, rd);
		wr(`IFSB_OFF_FOURTH, 32'h0);
		rdw(`IFSB_OFF_FOURTH);
		chk("flag written zero", 32'h0, rd);
		$display("test masked done");
	endtask

	// An unmapped address is refused and leaves the flags alone.
	task automatic t_unmapped;
		wr(12'h020, 32'hffff);
		chk("write error", 32'h1, er);
		rdw(12'h020);
		chk("read error", 32'h1, er);
		rdw(`IFSB_OFF_THIRD);
		chk("third untouched", 32'h0, rd);
		wr(`IFSB_OFF_PENDING, 32'hffff);
		chk("pending write accepted", 32'h0, er);
		rdw(`IFSB_OFF_THIRD);
		chk("pending write ignored", 32'h0, rd);
		$display("test unmapped done");
	endtask

	// A source held high through a software write or clear keeps its flag set.
	task automatic t_collide;
		@(posedge pclk);
		ev[1] <= 1'b1;
		wr(`IFSB_OFF_THIRD, 32'h0);
		ev[1] <= 1'b0;
		chk("mapped write error", 32'h0, er);
		rdw(`IFSB_OFF_THIRD);
		chk("set beats write", 32'h4, rd);
		@(posedge pclk);
		ev[1] <= 1'b1;
		wr(`IFSB_OFF_CLR_THIRD, 32'h4);
		ev[1] <= 1'b0;
		rdw(`IFSB_OFF_THIRD);
		chk("set beats clear", 32'h4, rd);
		wr(`IFSB_OFF_CLR_THIRD, 32'h4);
		rdw(`IFSB_OFF_THIRD);
		chk("cleared after collision", 32'h0, rd);
		$display("test collision done");
	endtask

	// With the enable low a source pulse is not taken.
	task automatic t_freeze;
		@(posedge pclk);
		pce <= 1'b0;
		pulse(2);
		@(posedge pclk);
		pce <= 1'b1;
		rdw(`IFSB_OFF_THIRD);
		chk("frozen source", 32'h0, rd);
		$display("test freeze done");
	endtask

	// A reset in mid-run clears a set flag, its mask and the interrupt.
	task automatic t_midreset;
		wr(`IFSB_OFF_MASK_THIRD, 32'h4000);
		pulse(0);
		repeat (2) @(posedge pclk);
		chk("irq before reset", 32'h1, {31'h0, irq});
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdw(`IFSB_OFF_THIRD);
		chk("third after mid reset", 32'h0, rd);
		rdw(`IFSB_OFF_MASK_THIRD);
		chk("mask after mid reset", 32'h0, rd);
		chk("irq after mid reset", 32'h0, {31'h0, irq});
		$display("test mid reset done");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		report_and_stop();
	end

	// Main sequence.
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_src(0, 1'b0, 14);
		t_src(1, 1'b0, 2);
		t_src(2, 1'b0, 1);
		t_src(3, 1'b1, 8);
		t_src(4, 1'b1, 3);
		t_src(5, 1'b1, 2);
		t_src(6, 1'b1, 1);
		t_unimpl();
		t_masked();
		t_collide();
		t_freeze();
		t_unmapped();
		t_midreset();
		report_and_stop();
	end
endmodule // tb
